// ==== clkgen_map.vh ====
// Purpose: register map, field positions and reset values of the
//          master clock generator
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register
// Notes:   definitions only, no logic
`ifndef CLKGEN_MAP_VH
`define CLKGEN_MAP_VH

// register byte addresses
`define CTRL_OFFSET      8'h00
`define SYSCFG_OFFSET    8'h04
`define STATUS_OFFSET    8'h08

// clock_gen_control_reg field positions
`define MODE_LSB         0
`define IDIV_LSB         4
`define ODIV_LSB         8
`define MUL_LSB          16
`define BAND_LSB         24
// system_config_reg_one field position
`define HALVE_BIT        0

// reset values
`define MODE_RST         2'h0
`define IDIV_RST         2'h0
`define ODIV_RST         4'h0
`define MUL_RST          5'h00
`define BAND_RST         2'h0
`define HALVE_RST        1'b0

// mode and band encodings, divider limits
`define MODE_MULT        2'h3
`define BAND_RSVD        2'h3
`define IDIV_MAX         2'h3
`define ODIV_MAX         4'hE

// step limits of the multiplier oscillator per band
`define BAND0_MIN        16'h0001
`define BAND0_MAX        16'h1000
`define BAND1_MIN        16'h1000
`define BAND1_MAX        16'h2000
`define BAND2_MIN        16'h2000
`define BAND2_MAX        16'h4000

// bus responses
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// ==== freq_loop.v ====
// Purpose: digital frequency multiplier loop; a phase accumulator whose
//          step is trimmed until its half-period count per reference
//          window matches the requested multiplier
// Assumes: osc_rise is a one-cycle pulse on the synchronised oscillator
// Notes:   half_tick marks one half period of the intermediate clock
`timescale 1ns/1ps
`include "clkgen_map.vh"
module freq_loop
#(
    parameter [15:0] GAIN = 16'h0010
)
(
    // clock and reset
    input  wire        clk,
    input  wire        rst,
    // control
    input  wire        enable,
    input  wire        osc_rise,
    input  wire [1:0]  idiv,
    input  wire [4:0]  mul,
    input  wire [1:0]  band,
    // results
    output reg         half_tick,
    output reg         locked,
    output reg  [15:0] step
);

    reg  [15:0] acc;
    reg  [1:0]  win_cnt;
    reg  [7:0]  tick_cnt;
    reg  [15:0] next_step;
    wire [16:0] sum = {1'b0, acc} + {1'b0, step};
    wire [5:0]  mul_p1 = {1'b0, mul} + 6'h01;
    wire [7:0]  target = {1'b0, mul_p1, 1'b0};
    wire [16:0] up = {1'b0, step} + {1'b0, GAIN};

    // lowest step of a band
    function [15:0] band_min;
        input [1:0] b;
        begin
            case (b)
                2'h1:    band_min = `BAND1_MIN;
                2'h2:    band_min = `BAND2_MIN;
                default: band_min = `BAND0_MIN;
            endcase
        end
    endfunction

    // highest step of a band
    function [15:0] band_max;
        input [1:0] b;
        begin
            case (b)
                2'h1:    band_max = `BAND1_MAX;
                2'h2:    band_max = `BAND2_MAX;
                default: band_max = `BAND0_MAX;
            endcase
        end
    endfunction

    // bounded step change
    // step moves one gain unit per window, but jumps to the band edge when the selected band changes
    always @*
    begin
        next_step = step;
        if (tick_cnt < target)
            next_step = (up[15:0] > band_max(band) || up[16]) ?
                        band_max(band) : up[15:0];
        else if (tick_cnt > target)
            next_step = (step < band_min(band) + GAIN) ?
                        band_min(band) : step - GAIN;
        if (next_step > band_max(band))
            next_step = band_max(band);
        if (next_step < band_min(band))
            next_step = band_min(band);
    end

    // accumulator, reference window and step update
    always @(posedge clk)
    begin
        if (rst || !enable)
        begin
            acc       <= 16'h0000;
            win_cnt   <= 2'h0;
            tick_cnt  <= 8'h00;
            half_tick <= 1'b0;
            locked    <= 1'b0;
            step      <= band_min(band);
        end
        else
        begin
            acc       <= sum[15:0];
            half_tick <= sum[16];
            if (osc_rise && win_cnt == idiv)
            begin
                win_cnt  <= 2'h0;
                tick_cnt <= 8'h00;
                locked   <= (tick_cnt == target);
                step     <= next_step;
            end
            else
            begin
                if (osc_rise)
                    win_cnt <= win_cnt + 2'h1;
                if (sum[16] && tick_cnt != 8'hFF)
                    tick_cnt <= tick_cnt + 8'h01;
            end
        end
    end

endmodule

// ==== master_clock_gen.v ====
// Purpose: master clock generation with prescaler bypass and frequency
//          multiplier modes, plus the cpu and system clock stage
// Assumes: oscillator pin is asynchronous and much slower than CLK;
//          generated clocks are levels sampled on CLK
// Notes:   registers reached over AXI4-Lite, one aligned word each
//
// Overview of operation
// - bypass: master clock is oscillator over (in div+1)*(out div+1)
// - bypass with both dividers zero: master clock follows oscillator
// - input divider max 3, output max 14, slowest ratio is 60
// - multiplier encoding enables the multiplier, master from its output
// - multiplier: osc*(mul+1)/((in div+1)*(out div+1))
// - multiplier locks gradually; frequency jumps only when a band change clamps the step to the new band
// - intermediate clock divided by output divider plus one
// - cpu clock equals master clock or half of it, one select bit
// - system clock always runs at the cpu clock frequency
// - mode is taken from the software-written control register
// - band field: 00, 01, 10 rising ranges, 11 reserved
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "clkgen_map.vh"
module master_clock_gen
#(
    parameter        ADDR_W    = 8,
    parameter [15:0] LOOP_GAIN = 16'h0010
)
(
    // clock and reset
    input  wire              CLK,
    input  wire              SYS_RST,
    // oscillator pin
    input  wire              OSCILLATOR_INPUT_PIN,
    // axi4-lite write address
    input  wire [ADDR_W-1:0] S_AXI_AWADDR,
    input  wire              S_AXI_AWVALID,
    output reg               S_AXI_AWREADY,
    // axi4-lite write data
    input  wire [31:0]       S_AXI_WDATA,
    input  wire [3:0]        S_AXI_WSTRB,
    input  wire              S_AXI_WVALID,
    output reg               S_AXI_WREADY,
    // axi4-lite write response
    output reg  [1:0]        S_AXI_BRESP,
    output reg               S_AXI_BVALID,
    input  wire              S_AXI_BREADY,
    // axi4-lite read address
    input  wire [ADDR_W-1:0] S_AXI_ARADDR,
    input  wire              S_AXI_ARVALID,
    output reg               S_AXI_ARREADY,
    // axi4-lite read data
    output reg  [31:0]       S_AXI_RDATA,
    output reg  [1:0]        S_AXI_RRESP,
    output reg               S_AXI_RVALID,
    input  wire              S_AXI_RREADY,
    // generated clocks and status
    output reg               MASTER_CLK,
    output reg               CPU_CLK,
    output reg               SYS_CLK,
    output reg               LOCKED
);

    // clock_gen_control_reg fields
    reg  [1:0]        clock_source_mode_field;
    reg  [1:0]        input_divider_value;
    reg  [3:0]        output_divider_value;
    reg  [4:0]        multiplier_value;
    reg  [1:0]        osc_band_select;
    // system_config_reg_one field
    reg               cpu_clock_halve_select;

    // bus slave state
    reg               aw_hold;
    reg  [ADDR_W-1:0] aw_addr;
    reg               w_hold;
    reg  [31:0]       w_data;
    reg  [3:0]        w_strb;

    // oscillator synchroniser and edge detect
    reg               osc_meta;
    reg               osc_sync;
    reg               osc_prev;

    // master divider
    reg  [7:0]        div_cnt;
    reg               next_mc;
    reg               next_cpu;
    reg  [31:0]       merged;

    wire              loop_tick;
    wire              loop_locked;
    wire [15:0]       loop_step;

    // mode decode, shared by the divider and status paths
    function is_bypass;
        input [1:0] m;
        begin
            is_bypass = ~m[1];
        end
    endfunction

    function is_mult;
        input [1:0] m;
        begin
            is_mult = (m == `MODE_MULT);
        end
    endfunction

    // byte-lane merge of a write into an existing word
    function [31:0] merge;
        input [31:0] old;
        input [31:0] wd;
        input [3:0]  strb;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1)
                if (strb[i])
                    merge[i*8 +: 8] = wd[i*8 +: 8];
        end
    endfunction

    // address word decode, used on both bus paths
    function mapped;
        input [ADDR_W-1:0] a;
        begin
            mapped = (a[7:0] == `CTRL_OFFSET) ||
                     (a[7:0] == `SYSCFG_OFFSET) ||
                     (a[7:0] == `STATUS_OFFSET);
        end
    endfunction

    wire        bypass = is_bypass(clock_source_mode_field);
    wire        mult   = is_mult(clock_source_mode_field);
    wire        osc_rise = osc_sync & ~osc_prev;
    wire        osc_edge = osc_sync ^ osc_prev;
    wire [2:0]  idiv_p1 = {1'b0, input_divider_value} + 3'h1;
    wire [4:0]  odiv_p1 = {1'b0, output_divider_value} + 5'h01;
    wire [7:0]  n_byp = {5'h00, idiv_p1} * {3'h0, odiv_p1};
    // output prescaler only in multiplier mode
    wire [7:0]  n_sel = bypass ? n_byp : {3'h0, odiv_p1};
    wire        div_event = bypass ? osc_edge : (mult & loop_tick);

    wire [31:0] ctrl_word = {6'h00, osc_band_select, 3'h0,
                             multiplier_value, 4'h0, output_divider_value,
                             2'h0, input_divider_value, 2'h0,
                             clock_source_mode_field};
    wire [31:0] cfg_word  = {31'h0000_0000, cpu_clock_halve_select};
    wire [31:0] stat_word = {loop_step, 13'h0000, mult,
                             MASTER_CLK, LOCKED};

    // multiplier runs only in multiplier mode
    freq_loop
    #(
        .GAIN      (LOOP_GAIN)
    )
    u_loop
    (
        .clk       (CLK),
        .rst       (SYS_RST),
        .enable    (mult),
        .osc_rise  (osc_rise),
        .idiv      (input_divider_value),
        .mul       (multiplier_value),
        .band      (osc_band_select),
        .half_tick (loop_tick),
        .locked    (loop_locked),
        .step      (loop_step)
    );

    // two flops before any logic sees the pin
    always @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            osc_meta <= 1'b0;
            osc_sync <= 1'b0;
            osc_prev <= 1'b0;
        end
        else
        begin
            osc_meta <= OSCILLATOR_INPUT_PIN;
            osc_sync <= osc_meta;
            osc_prev <= osc_sync;
        end
    end

    // next master clock level; toggling every n half periods of the
    // source keeps an even duty cycle for odd ratios too
    always @*
    begin
        next_mc = MASTER_CLK;
        if (bypass && n_sel == 8'h01)
            next_mc = osc_sync;
        else if (!bypass && !mult)
            // reserved mode encoding stops the clock low
            next_mc = 1'b0;
        else if (div_event && div_cnt + 8'h01 >= n_sel)
            // toggle after n source half periods
            next_mc = ~MASTER_CLK;
    end

    // cpu clock level from the master clock
    always @*
    begin
        next_cpu = next_mc;
        // optional halving on master rising edges
        if (cpu_clock_halve_select)
        begin
            next_cpu = CPU_CLK;
            if (next_mc && !MASTER_CLK)
                next_cpu = ~CPU_CLK;
        end
    end

    // master divider counter and generated clock flops
    always @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            div_cnt    <= 8'h00;
            MASTER_CLK <= 1'b0;
            CPU_CLK    <= 1'b0;
            SYS_CLK    <= 1'b0;
            LOCKED     <= 1'b0;
        end
        else
        begin
            MASTER_CLK <= next_mc;
            CPU_CLK    <= next_cpu;
            SYS_CLK    <= next_cpu;
            LOCKED     <= mult & loop_locked;
            // >= compare lets a smaller new ratio take effect at once
            if (div_event)
            begin
                if (div_cnt + 8'h01 >= n_sel)
                    div_cnt <= 8'h00;
                else
                    div_cnt <= div_cnt + 8'h01;
            end
        end
    end

    // merged write word for the addressed register
    always @*
    begin
        if (aw_addr[7:0] == `SYSCFG_OFFSET)
            merged = merge(cfg_word, w_data, w_strb);
        else
            merged = merge(ctrl_word, w_data, w_strb);
    end

    // write channels: address and data taken in either order, then
    // one response; a second write waits until the response is taken
    always @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= `RESP_OKAY;
            aw_hold       <= 1'b0;
            aw_addr       <= {ADDR_W{1'b0}};
            w_hold        <= 1'b0;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            clock_source_mode_field <= `MODE_RST;
            input_divider_value     <= `IDIV_RST;
            output_divider_value    <= `ODIV_RST;
            multiplier_value        <= `MUL_RST;
            osc_band_select         <= `BAND_RST;
            cpu_clock_halve_select  <= `HALVE_RST;
        end
        else
        begin
            if (S_AXI_AWVALID && S_AXI_AWREADY)
            begin
                aw_hold       <= 1'b1;
                aw_addr       <= S_AXI_AWADDR;
                S_AXI_AWREADY <= 1'b0;
            end
            else if (!aw_hold && !S_AXI_BVALID)
                S_AXI_AWREADY <= 1'b1;

            if (S_AXI_WVALID && S_AXI_WREADY)
            begin
                w_hold       <= 1'b1;
                w_data       <= S_AXI_WDATA;
                w_strb       <= S_AXI_WSTRB;
                S_AXI_WREADY <= 1'b0;
            end
            else if (!w_hold && !S_AXI_BVALID)
                S_AXI_WREADY <= 1'b1;

            if (S_AXI_BVALID && S_AXI_BREADY)
                S_AXI_BVALID <= 1'b0;

            if (aw_hold && w_hold && !S_AXI_BVALID)
            begin
                aw_hold      <= 1'b0;
                w_hold       <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= mapped(aw_addr) ?
                                `RESP_OKAY : `RESP_SLVERR;
                if (aw_addr[7:0] == `CTRL_OFFSET)
                begin
                    clock_source_mode_field <=
                        merged[`MODE_LSB+1:`MODE_LSB];
                    input_divider_value <= merged[`IDIV_LSB+1:`IDIV_LSB];
                    // output divider saturates at its maximum
                    if (merged[`ODIV_LSB+3:`ODIV_LSB] > `ODIV_MAX)
                        output_divider_value <= `ODIV_MAX;
                    else
                        output_divider_value <=
                            merged[`ODIV_LSB+3:`ODIV_LSB];
                    multiplier_value <= merged[`MUL_LSB+4:`MUL_LSB];
                    if (merged[`BAND_LSB+1:`BAND_LSB] != `BAND_RSVD)
                        osc_band_select <= merged[`BAND_LSB+1:`BAND_LSB];
                end
                if (aw_addr[7:0] == `SYSCFG_OFFSET)
                    cpu_clock_halve_select <= merged[`HALVE_BIT];
            end
        end
    end

    // read channel: data is sampled at the address handshake
    always @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h0000_0000;
            S_AXI_RRESP   <= `RESP_OKAY;
        end
        else
        begin
            if (S_AXI_ARVALID && S_AXI_ARREADY)
            begin
                S_AXI_ARREADY <= 1'b0;
                S_AXI_RVALID  <= 1'b1;
                S_AXI_RRESP   <= mapped(S_AXI_ARADDR) ?
                                 `RESP_OKAY : `RESP_SLVERR;
                case (S_AXI_ARADDR[7:0])
                    `CTRL_OFFSET:   S_AXI_RDATA <= ctrl_word;
                    `SYSCFG_OFFSET: S_AXI_RDATA <= cfg_word;
                    `STATUS_OFFSET: S_AXI_RDATA <= stat_word;
                    default:        S_AXI_RDATA <= 32'h0000_0000;
                endcase
            end
            else
            begin
                if (S_AXI_RVALID && S_AXI_RREADY)
                    S_AXI_RVALID <= 1'b0;
                if (!S_AXI_RVALID)
                    S_AXI_ARREADY <= 1'b1;
            end
        end
    end

endmodule

// ==== master_clock_gen_sva.sv ====
// Purpose: port checker for the master clock generator
// Assumes: one clock domain, synchronous active high reset
// Notes:   control registers are not visible here, only handshakes
//          and the relations between the generated clocks
`timescale 1ns/1ps
`include "clkgen_map.vh"
module master_clock_gen_sva
#(
    parameter ADDR_W = 8
)
(
    // clock and reset
    input logic              CLK,
    input logic              SYS_RST,
    // bus handshakes
    input logic              S_AXI_AWVALID,
    input logic              S_AXI_AWREADY,
    input logic              S_AXI_WVALID,
    input logic              S_AXI_WREADY,
    input logic [1:0]        S_AXI_BRESP,
    input logic              S_AXI_BVALID,
    input logic              S_AXI_BREADY,
    input logic [ADDR_W-1:0] S_AXI_ARADDR,
    input logic              S_AXI_ARVALID,
    input logic              S_AXI_ARREADY,
    input logic [31:0]       S_AXI_RDATA,
    input logic [1:0]        S_AXI_RRESP,
    input logic              S_AXI_RVALID,
    input logic              S_AXI_RREADY,
    // generated clocks
    input logic              MASTER_CLK,
    input logic              CPU_CLK,
    input logic              SYS_CLK,
    input logic              LOCKED
);
    // master level one and two cycles back
    logic mq;
    logic mqq;
    always @(posedge CLK)
    begin
        mq  <= MASTER_CLK;
        mqq <= mq;
    end

    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    property p_sys; SYS_CLK == CPU_CLK; endproperty
    a_sys: assert property (p_sys)
        else $error("sys clock not cpu clock");
    property p_cpu;
        $changed(CPU_CLK) |->
            CPU_CLK == MASTER_CLK || MASTER_CLK != mq || mq != mqq;
    endproperty
    a_cpu: assert property (p_cpu)
        else $error("cpu clock moved alone");
    property p_bhold;
        S_AXI_BVALID && !S_AXI_BREADY |=>
            S_AXI_BVALID && $stable(S_AXI_BRESP);
    endproperty
    a_bhold: assert property (p_bhold)
        else $error("write response not held");
    property p_rhold;
        S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID
            && $stable(S_AXI_RDATA) && $stable(S_AXI_RRESP);
    endproperty
    a_rhold: assert property (p_rhold)
        else $error("read answer not held");
    property p_bans;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
            |=> ##1 S_AXI_BVALID;
    endproperty
    a_bans: assert property (p_bans)
        else $error("write response late");
    property p_rans; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
    endproperty
    a_rans: assert property (p_rans)
        else $error("read answer late");
    property p_rerr;
        S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR > 8'h08 |=>
            S_AXI_RRESP == `RESP_SLVERR && S_AXI_RDATA == 32'h0000_0000;
    endproperty
    a_rerr: assert property (p_rerr)
        else $error("unmapped read not refused");
    property p_busy;
        S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY;
    endproperty
    a_busy: assert property (p_busy)
        else $error("write ready while busy");
    property p_rbusy; S_AXI_RVALID |-> !S_AXI_ARREADY; endproperty
    a_rbusy: assert property (p_rbusy)
        else $error("read ready while busy");
    // reset is the one condition checked while reset is applied
    property p_rst;
        disable iff (1'b0) SYS_RST |=> !S_AXI_BVALID && !S_AXI_RVALID
            && !MASTER_CLK && !CPU_CLK && !LOCKED;
    endproperty
    a_rst: assert property (p_rst)
        else $error("outputs active after reset");
endmodule

bind master_clock_gen master_clock_gen_sva #(.ADDR_W(ADDR_W))
    master_clock_gen_sva_inst
(
    .CLK(CLK), .SYS_RST(SYS_RST),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
    .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
    .MASTER_CLK(MASTER_CLK), .CPU_CLK(CPU_CLK), .SYS_CLK(SYS_CLK),
    .LOCKED(LOCKED)
);

// ==== testbench.sv ====
// Purpose: self-checking bench for the master clock generator
// Assumes: oscillator made here, 6 or 10 clock cycles a period
// Notes:   bus answers are checked in order through queues
`timescale 1ns/1ps
`include "clkgen_map.vh"
module testbench;
    // clock, reset, oscillator
    logic        CLK = 0;
    logic        SYS_RST = 1;
    logic        osc = 0;
    integer      osc_half = 3;
    integer      oc = 0;
    // bus master side
    logic [7:0]  awaddr = 0;
    logic        awvalid = 0;
    logic [31:0] wdata = 0;
    logic [3:0]  wstrb = 0;
    logic        wvalid = 0;
    logic        bready = 0;
    logic [7:0]  araddr = 0;
    logic        arvalid = 0;
    logic        rready = 0;
    // design outputs
    wire  [1:0]  bresp;
    wire  [1:0]  rresp;
    wire  [31:0] rdata;
    wire         awready, wready, bvalid, arready, rvalid;
    wire         mclk, cclk, sclk, locked;
    // expected answers and counters
    logic [1:0]  bq[$];
    logic [65:0] rq[$];
    logic [65:0] re;
    integer      n_mismatch = 0;
    integer      checks_done = 0;
    integer      cyc = 0;
    integer      t, i, o, m, n, p, h;

    master_clock_gen #(.LOOP_GAIN(16'h0100)) master_clock_gen_inst
    (
        .CLK(CLK), .SYS_RST(SYS_RST), .OSCILLATOR_INPUT_PIN(osc),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .MASTER_CLK(mclk), .CPU_CLK(cclk),
        .SYS_CLK(sclk), .LOCKED(locked)
    );

    always #12.5 CLK = ~CLK;

    // oscillator pin and the hang limit
    always @(posedge CLK)
    begin
        cyc <= cyc + 1;
        if (oc >= osc_half - 1)
        begin
            oc  <= 0;
            osc <= ~osc;
        end
        else
            oc <= oc + 1;
        if (cyc == 90000)
        begin
            n_mismatch = n_mismatch + 1;
            end_sim;
        end
    end

    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        begin
            checks_done = checks_done + 1;
            if (e !== s)
            begin
                n_mismatch = n_mismatch + 1;
                $display("mismatch %s expected %h seen %h", nm, e, s);
            end
        end
    endtask

    // monitor: oldest note against each taken answer
    always @(posedge CLK)
    begin
        if (bvalid && bready && bq.size() > 0)
            chk("bresp", bq.pop_front(), bresp);
        if (rvalid && rready && rq.size() > 0)
        begin
            re = rq.pop_front();
            chk("rresp", re[65:64], rresp);
            chk("rdata", re[31:0], rdata & re[63:32]);
        end
    end

    // ready is raised late at random so the answer must stand
    task automatic wr(input [7:0] a, input [31:0] d,
                      input [3:0] s = 4'hF, input [1:0] er = `RESP_OKAY);
        integer k;
        begin
            k = $urandom % 3;
            bq.push_back(er);
            awaddr  <= a;
            wdata   <= d;
            wstrb   <= s;
            awvalid <= 1;
            wvalid  <= 1;
            do
            begin
                @(posedge CLK);
                if (awready)
                    awvalid <= 0;
                if (wready)
                    wvalid <= 0;
                if (k == 0)
                    bready <= 1;
                else
                    k = k - 1;
            end
            while (!(bvalid && bready));
            bready <= 0;
            @(posedge CLK);
        end
    endtask

    task automatic rd(input [7:0] a, input [31:0] e,
                      input [31:0] mk = 32'hFFFF_FFFF,
                      input [1:0] er = `RESP_OKAY);
        integer k;
        begin
            k = $urandom % 3;
            rq.push_back({er, mk, e});
            araddr  <= a;
            arvalid <= 1;
            do
            begin
                @(posedge CLK);
                if (arready)
                    arvalid <= 0;
                if (k == 0)
                    rready <= 1;
                else
                    k = k - 1;
            end
            while (!(rvalid && rready));
            rready <= 0;
            @(posedge CLK);
        end
    endtask

    // cycles over np periods of a clock, and how many of them high
    task automatic meas(input bit c, input integer np, output integer pp,
                        output integer hh);
        integer r;
        logic   q;
        logic   v;
        begin
            r = 0;
            pp = 0;
            hh = 0;
            q = 1;
            while (r <= np)
            begin
                @(posedge CLK);
                v = c ? cclk : mclk;
                if (v && !q)
                    r = r + 1;
                if (r >= 1 && r <= np)
                begin
                    pp = pp + 1;
                    hh = hh + v;
                end
                q = v;
            end
        end
    endtask

    task end_sim;
        begin
            if (n_mismatch == 0 && checks_done > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask

    initial
    begin
        void'($urandom(32'h3359));
        repeat (6) @(posedge CLK);
        SYS_RST <= 0;
        @(posedge CLK);
        // reset values, unmapped places refused
        rd(`CTRL_OFFSET, 0);
        rd(`SYSCFG_OFFSET, 0);
        rd(8'h10, 0, 32'hFFFF_FFFF, `RESP_SLVERR);
        wr(8'h0C, 32'hFFFF_FFFF, 4'hF, `RESP_SLVERR);
        // bypass ratios: plain, slowest, saturated, then random
        for (t = 0; t < 6; t = t + 1)
        begin
            i = (t == 0) ? 0 : (t < 3) ? 3 : $urandom % 4;
            o = (t == 0) ? 0 : (t < 3) ? 13 + t : $urandom % 15;
            m = (o > 14) ? 14 : o;
            n = (i + 1) * (m + 1);
            wr(`CTRL_OFFSET, (o << 8) | (i << 4) | (t % 2));
            rd(`CTRL_OFFSET, (m << 8) | (i << 4) | (t % 2));
            meas(0, 3, p, h);
            meas(0, 2, p, h);
            chk("master period", 4 * n * osc_half, p);
            chk("master high", 2 * n * osc_half, h);
        end
        // halved cpu clock; a write missing lane 0 keeps the select
        wr(`SYSCFG_OFFSET, 1);
        wr(`SYSCFG_OFFSET, 0, 4'hE);
        rd(`SYSCFG_OFFSET, 1);
        meas(1, 2, p, h);
        meas(1, 2, p, h);
        chk("cpu period", 8 * n * osc_half, p);
        chk("sys clock", cclk, sclk);
        wr(`SYSCFG_OFFSET, 0);
        meas(1, 2, p, h);
        meas(1, 2, p, h);
        chk("cpu period", 4 * n * osc_half, p);
        // stopped clock; a reserved band write leaves the band alone
        wr(`CTRL_OFFSET, 32'h0200_0002);
        wr(`CTRL_OFFSET, 32'h0300_0002);
        rd(`CTRL_OFFSET, 32'h0200_0002);
        while (mclk)
            @(posedge CLK);
        rd(`STATUS_OFFSET, 0, 32'h0000_0007);
        // multiplier: 10-cycle oscillator times 4/(4*2)
        osc_half = 5;
        wr(`CTRL_OFFSET, 32'h0203_0133);
        while (!locked)
            @(posedge CLK);
        rd(`STATUS_OFFSET, 32'h0000_0005, 32'h0000_0005);
        meas(0, 8, p, h);
        chk("mult period", 1, p > 144 && p < 176);
        end_sim;
    end
endmodule
